// [design/ptsdp_map.vh]
/*
  Constants for the pattern trigger and serial data port: register
  offsets, control bit positions, reset values and timing figures.
  Assumes it is included by bare name from the design files.
*/
`ifndef PTSDP_MAP_VH
`define PTSDP_MAP_VH

// ----------------------------------------------------------------------
// bus and register offsets (byte addresses)
// ----------------------------------------------------------------------
`define PTS_AW           8
`define PTS_OFS_CTRL     8'h00
`define PTS_OFS_BITDIV   8'h04
`define PTS_OFS_FRMLEN   8'h08
`define PTS_OFS_EVOFS    8'h0C
`define PTS_OFS_MKPOL    8'h10
`define PTS_OFS_MKROUTE  8'h14
`define PTS_OFS_WAVECFG  8'h18
`define PTS_OFS_WAVEDAT  8'h1C
`define PTS_OFS_STATUS   8'h20
`define PTS_OFS_RXSYM    8'h24
`define PTS_OFS_SYMLEN   8'h28
`define PTS_OFS_PATWORD  8'h2C
`define PTS_RESP_OKAY    2'b00
`define PTS_RESP_SLVERR  2'b10

// ----------------------------------------------------------------------
// control bits
// ----------------------------------------------------------------------
`define PTS_CTRL_RUN     0
`define PTS_CTRL_CONT    1
`define PTS_CTRL_FALL    2
`define PTS_CTRL_EXTCLK  3
`define PTS_CTRL_INTBB   4
`define PTS_CTRL_EXTGATE 5

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define PTS_RST_CTRL     6'h10
`define PTS_RST_BITDIV   16'h0002
`define PTS_RST_FRMLEN   16'h0020
`define PTS_RST_MKROUTE  12'h688
`define PTS_RST_SYMLEN   5'h01
`define PTS_RST_WLAST    6'h3F

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define PTS_CLK_MHZ      200
`define PTS_BITCLK_MAX_MHZ 50
// ceiling of clock rate over twice the top bit clock rate, in clocks
`define PTS_MIN_HALF     16'h0002
`define PTS_TRIG_MIN_NS  10
`define PTS_ARM_START    2'd2
`define PTS_ARM_LAST     2'd1
`define PTS_ARM_IDLE     2'd0

// ----------------------------------------------------------------------
// marker route sources
// ----------------------------------------------------------------------
`define PTS_SRC_EVENT    3'd4
`define PTS_SRC_SYMSTART 3'd5
`define PTS_SRC_DEN      3'd6

`endif

// [design/ptsdp_sync.v]
/*
  Two-flop synchroniser for a bundle of independent level inputs.
  Assumes each bit is a slow level or a clock well below clock_i.
*/
`timescale 1ns/100ps
`default_nettype none

module ptsdp_sync #(
  parameter WIDTH = 4
) (
  input  wire             clock_i,
  input  wire             rst_b_i,
  input  wire [WIDTH-1:0] async_i,
  output wire [WIDTH-1:0] sync_o
);

  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] sync_reg;

  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_reg <= {WIDTH{1'b0}};
      sync_reg <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= async_i;
      sync_reg <= meta_reg;
    end
  end

  assign sync_o = sync_reg;

endmodule // ptsdp_sync

`default_nettype wire

// [design/ptsdp_marker_mem.v]
/*
  Per-point marker flag store: 64 waveform points, four flags each.
  Assumes one write port from the register slave and an unregistered
  read indexed by the playback point counter.
*/
`timescale 1ns/100ps
`default_nettype none

module ptsdp_marker_mem (
  input  wire       clock_i,
  input  wire       wr_en_i,
  input  wire [5:0] wr_addr_i,
  input  wire [3:0] wr_flags_i,
  input  wire [5:0] rd_addr_i,
  output wire [3:0] rd_flags_o
);

  reg [3:0] flag_mem [0:63];

  always @(posedge clock_i) begin
    if (wr_en_i) begin
      flag_mem[wr_addr_i] <= wr_flags_i;
    end
  end

  assign rd_flags_o = flag_mem[rd_addr_i];

endmodule // ptsdp_marker_mem

`default_nettype wire

// [design/ptsdp_top.v]
/*
  Pattern trigger, marker, event and external serial data port with an
  AXI4-Lite register slave. Assumes clock_i at 200 MHz; the four external
  input pins come from outside the clock domain and are synchronised here.
*/
// Behaviour
// - the trigger edge is latched and the latch is sampled at the bit clock falling edge.
// - a qualified trigger starts one pattern in single mode, or halts and restarts it in continuous mode.
// - the trigger acts on a rising or a falling edge, as configured.
// - trigger levels last at least 10 ns and pulses that short are caught.
// - the first frame bit leaves 1.5 to 2.5 bit periods after the trigger edge.
// - a frame event pulse marks frame start, shiftable by one timeslot either way in whole bits.
// - each waveform point holds marker flags and marker 1 follows the first flag.
// - each marker output has a polarity, negative inverting it.
// - the four flags, frame event, symbol start and data enable can each be routed to any of the four marker lines.
// - with the internal baseband in use the bit clock is driven out.
// - high on the serial data input is a one and low a zero.
// - serial data and symbol sync are sampled at the external clock falling edge.
// - the external data path runs up to 50 Mb/s with a clock up to 50 MHz.
// - an active-low data enable is low while a pattern runs with EXTGATE set; serial receive does not use it.
`timescale 1ns/100ps
`default_nettype none
`include "ptsdp_map.vh"

module ptsdp_top (
  input  wire                clock_i,
  input  wire                rst_b_i,
  input  wire [`PTS_AW-1:0]  s_axi_awaddr_i,
  input  wire                s_axi_awvalid_i,
  output wire                s_axi_awready_o,
  input  wire [31:0]         s_axi_wdata_i,
  input  wire [3:0]          s_axi_wstrb_i,
  input  wire                s_axi_wvalid_i,
  output wire                s_axi_wready_o,
  output reg  [1:0]          s_axi_bresp_o,
  output reg                 s_axi_bvalid_o,
  input  wire                s_axi_bready_i,
  input  wire [`PTS_AW-1:0]  s_axi_araddr_i,
  input  wire                s_axi_arvalid_i,
  output wire                s_axi_arready_o,
  output reg  [31:0]         s_axi_rdata_o,
  output reg  [1:0]          s_axi_rresp_o,
  output reg                 s_axi_rvalid_o,
  input  wire                s_axi_rready_i,
  input  wire                pattern_trigger_input_i,
  input  wire                ext_data_clock_i,
  input  wire                ext_data_i,
  input  wire                ext_symbol_sync_i,
  output reg                 serial_data_o,
  output reg                 data_clock_o,
  output reg  [3:0]          marker_o,
  output reg                 frame_event_o,
  output reg                 data_enable_b_o,
  output reg                 baseband_trigger_port_a_o
);

  // --------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------
  function [31:0] merge_bytes;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0]  strb;
    integer k;
    begin
      merge_bytes = old_val;
      for (k = 0; k < 4; k = k + 1) begin
        if (strb[k]) begin
          merge_bytes[k*8 +: 8] = new_val[k*8 +: 8];
        end
      end
    end
  endfunction

  // event bit position, offset wrapped into one timeslot
  function [15:0] event_pos;
    input [16:0] ofs;
    input [15:0] len;
    reg   [16:0] s;
    begin
      s = ofs;
      if (ofs[16]) begin
        s = {1'b0, len} + ofs;
      end else if (ofs >= {1'b0, len}) begin
        s = ofs - {1'b0, len};
      end
      event_pos = s[15:0];
    end
  endfunction

  // --------------------------------------------------------------------
  // register file and bus slave
  // --------------------------------------------------------------------
  reg  [5:0]          ctrl_reg;
  reg  [15:0]         bitdiv_reg;
  reg  [15:0]         frmlen_reg;
  reg  [16:0]         evofs_reg;
  reg  [3:0]          mkpol_reg;
  reg  [11:0]         mkroute_reg;
  reg  [5:0]          waddr_reg;
  reg  [5:0]          wlast_reg;
  reg  [4:0]          symlen_reg;
  reg  [31:0]         patword_reg;
  reg                 aw_full_reg;
  reg                 w_full_reg;
  reg  [`PTS_AW-1:0]  aw_addr_reg;
  reg  [31:0]         w_data_reg;
  reg  [3:0]          w_strb_reg;
  reg  [31:0]         rd_val;
  reg                 rd_hit;
  reg                 wr_hit;
  reg  [31:0]         rxsym_reg;
  reg                 running_reg;
  reg                 pend_reg;
  wire                do_write;
  wire                mem_we;
  wire [31:0]         wval;
  wire [31:0]         ctrl_mrg;
  wire [31:0]         bitdiv_mrg;
  wire [31:0]         frmlen_mrg;

  assign s_axi_awready_o = !aw_full_reg && !s_axi_bvalid_o;
  assign s_axi_wready_o  = !w_full_reg && !s_axi_bvalid_o;
  assign s_axi_arready_o = !s_axi_rvalid_o;
  assign do_write = aw_full_reg && w_full_reg && !s_axi_bvalid_o;
  assign wval = merge_bytes(32'h0000_0000, w_data_reg, w_strb_reg);
  assign ctrl_mrg = merge_bytes({26'h000_0000, ctrl_reg}, w_data_reg,
                                w_strb_reg);
  assign bitdiv_mrg = merge_bytes({16'h0000, bitdiv_reg}, w_data_reg,
                                  w_strb_reg);
  assign frmlen_mrg = merge_bytes({16'h0000, frmlen_reg}, w_data_reg,
                                  w_strb_reg);
  assign mem_we = do_write && (aw_addr_reg == `PTS_OFS_WAVEDAT);

  always @* begin
    wr_hit = 1'b1;
    if (aw_addr_reg == `PTS_OFS_CTRL) begin
      wr_hit = 1'b1;
    end else if (aw_addr_reg == `PTS_OFS_BITDIV) begin
      wr_hit = 1'b1;
    end else if (aw_addr_reg == `PTS_OFS_FRMLEN) begin
      wr_hit = 1'b1;
    end else if (aw_addr_reg == `PTS_OFS_EVOFS) begin
      wr_hit = 1'b1;
    end else if (aw_addr_reg == `PTS_OFS_MKPOL) begin
      wr_hit = 1'b1;
    end else if (aw_addr_reg == `PTS_OFS_MKROUTE) begin
      wr_hit = 1'b1;
    end else if (aw_addr_reg == `PTS_OFS_WAVECFG) begin
      wr_hit = 1'b1;
    end else if (aw_addr_reg == `PTS_OFS_WAVEDAT) begin
      wr_hit = 1'b1;
    end else if (aw_addr_reg == `PTS_OFS_SYMLEN) begin
      wr_hit = 1'b1;
    end else if (aw_addr_reg == `PTS_OFS_PATWORD) begin
      wr_hit = 1'b1;
    end else begin
      wr_hit = 1'b0;
    end
  end

  always @* begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    if (s_axi_araddr_i == `PTS_OFS_CTRL) begin
      rd_val[5:0] = ctrl_reg;
    end else if (s_axi_araddr_i == `PTS_OFS_BITDIV) begin
      rd_val[15:0] = bitdiv_reg;
    end else if (s_axi_araddr_i == `PTS_OFS_FRMLEN) begin
      rd_val[15:0] = frmlen_reg;
    end else if (s_axi_araddr_i == `PTS_OFS_EVOFS) begin
      rd_val[16:0] = evofs_reg;
    end else if (s_axi_araddr_i == `PTS_OFS_MKPOL) begin
      rd_val[3:0] = mkpol_reg;
    end else if (s_axi_araddr_i == `PTS_OFS_MKROUTE) begin
      rd_val[11:0] = mkroute_reg;
    end else if (s_axi_araddr_i == `PTS_OFS_WAVECFG) begin
      rd_val[5:0] = waddr_reg;
      rd_val[21:16] = wlast_reg;
    end else if (s_axi_araddr_i == `PTS_OFS_WAVEDAT) begin
      rd_val = 32'h0000_0000;
    end else if (s_axi_araddr_i == `PTS_OFS_STATUS) begin
      rd_val[0] = running_reg;
      rd_val[1] = pend_reg;
    end else if (s_axi_araddr_i == `PTS_OFS_RXSYM) begin
      rd_val = rxsym_reg;
    end else if (s_axi_araddr_i == `PTS_OFS_SYMLEN) begin
      rd_val[4:0] = symlen_reg;
    end else if (s_axi_araddr_i == `PTS_OFS_PATWORD) begin
      rd_val = patword_reg;
    end else begin
      rd_hit = 1'b0;
    end
  end

  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      aw_full_reg    <= 1'b0;
      w_full_reg     <= 1'b0;
      aw_addr_reg    <= {`PTS_AW{1'b0}};
      w_data_reg     <= 32'h0000_0000;
      w_strb_reg     <= 4'h0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= `PTS_RESP_OKAY;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rresp_o  <= `PTS_RESP_OKAY;
      s_axi_rdata_o  <= 32'h0000_0000;
      ctrl_reg       <= `PTS_RST_CTRL;
      bitdiv_reg     <= `PTS_RST_BITDIV;
      frmlen_reg     <= `PTS_RST_FRMLEN;
      evofs_reg      <= 17'h0_0000;
      mkpol_reg      <= 4'h0;
      mkroute_reg    <= `PTS_RST_MKROUTE;
      waddr_reg      <= 6'h00;
      wlast_reg      <= `PTS_RST_WLAST;
      symlen_reg     <= `PTS_RST_SYMLEN;
      patword_reg    <= 32'h0000_0000;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata_i;
        w_strb_reg <= s_axi_wstrb_i;
      end
      if (do_write) begin
        aw_full_reg    <= 1'b0;
        w_full_reg     <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= wr_hit ? `PTS_RESP_OKAY : `PTS_RESP_SLVERR;
        if (aw_addr_reg == `PTS_OFS_CTRL) begin
          ctrl_reg <= ctrl_mrg[5:0];
        end else if (aw_addr_reg == `PTS_OFS_BITDIV) begin
          bitdiv_reg <= bitdiv_mrg[15:0];
        end else if (aw_addr_reg == `PTS_OFS_FRMLEN) begin
          frmlen_reg <= frmlen_mrg[15:0];
        end else if (aw_addr_reg == `PTS_OFS_EVOFS) begin
          evofs_reg <= wval[16:0];
        end else if (aw_addr_reg == `PTS_OFS_MKPOL) begin
          mkpol_reg <= wval[3:0];
        end else if (aw_addr_reg == `PTS_OFS_MKROUTE) begin
          mkroute_reg <= wval[11:0];
        end else if (aw_addr_reg == `PTS_OFS_WAVECFG) begin
          waddr_reg <= wval[5:0];
          wlast_reg <= wval[21:16];
        end else if (aw_addr_reg == `PTS_OFS_WAVEDAT) begin
          waddr_reg <= waddr_reg + 6'h01;
        end else if (aw_addr_reg == `PTS_OFS_SYMLEN) begin
          symlen_reg <= wval[4:0];
        end else if (aw_addr_reg == `PTS_OFS_PATWORD) begin
          patword_reg <= merge_bytes(patword_reg, w_data_reg, w_strb_reg);
        end
      end
      if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
      if (s_axi_arvalid_i && s_axi_arready_o) begin
        s_axi_rvalid_o <= 1'b1;
        s_axi_rdata_o  <= rd_val;
        s_axi_rresp_o  <= rd_hit ? `PTS_RESP_OKAY : `PTS_RESP_SLVERR;
      end else if (s_axi_rvalid_o && s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // pin synchronisers and edge finders
  // --------------------------------------------------------------------
  wire [3:0] pins_sync;
  reg        trig_d_reg;
  reg        eclk_d_reg;
  wire       trig_s;
  wire       eclk_s;

  ptsdp_sync #(
    .WIDTH (4)
  ) u_sync (
    .clock_i (clock_i),
    .rst_b_i (rst_b_i),
    .async_i ({ext_symbol_sync_i, ext_data_i, ext_data_clock_i,
               pattern_trigger_input_i}),
    .sync_o  (pins_sync)
  );

  assign trig_s = pins_sync[0];
  assign eclk_s = pins_sync[1];

  // --------------------------------------------------------------------
  // bit clock: internal divider or external data clock
  // --------------------------------------------------------------------
  reg  [15:0] div_cnt_reg;
  reg         bclk_reg;
  wire [15:0] half;
  wire        int_rise;
  wire        int_fall;
  wire        bit_rise;
  wire        bit_fall;
  wire        ext_rise;
  wire        ext_fall;

  // divider floor keeps the bit clock at or below its top rate
  assign half = (bitdiv_reg < `PTS_MIN_HALF) ? `PTS_MIN_HALF : bitdiv_reg;
  assign int_rise = (div_cnt_reg == half - 16'h0001) && !bclk_reg;
  assign int_fall = (div_cnt_reg == half - 16'h0001) && bclk_reg;
  assign ext_rise = eclk_s && !eclk_d_reg;
  assign ext_fall = !eclk_s && eclk_d_reg;
  assign bit_rise = ctrl_reg[`PTS_CTRL_EXTCLK] ? ext_rise : int_rise;
  assign bit_fall = ctrl_reg[`PTS_CTRL_EXTCLK] ? ext_fall : int_fall;

  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div_cnt_reg  <= 16'h0000;
      bclk_reg     <= 1'b0;
      trig_d_reg   <= 1'b0;
      eclk_d_reg   <= 1'b0;
      data_clock_o <= 1'b0;
    end else begin
      trig_d_reg <= trig_s;
      eclk_d_reg <= eclk_s;
      if (div_cnt_reg >= half - 16'h0001) begin
        div_cnt_reg <= 16'h0000;
        bclk_reg    <= !bclk_reg;
      end else begin
        div_cnt_reg <= div_cnt_reg + 16'h0001;
      end
      // follows the next bclk_reg so data and clock change together
      data_clock_o <= ctrl_reg[`PTS_CTRL_INTBB] &&
                      (bclk_reg ^ (div_cnt_reg >= half - 16'h0001));
    end
  end

  // --------------------------------------------------------------------
  // trigger qualification and pattern sequencer
  // --------------------------------------------------------------------
  reg  [1:0]  arm_reg;
  reg  [15:0] bit_cnt_reg;
  reg  [5:0]  point_reg;
  wire        trig_edge;
  wire        run_en;
  wire        cont;
  wire [15:0] ev_pos;

  assign run_en = ctrl_reg[`PTS_CTRL_RUN];
  assign cont   = ctrl_reg[`PTS_CTRL_CONT];
  // the 2-flop sample at 5 ns resolves any 10 ns level
  assign trig_edge = ctrl_reg[`PTS_CTRL_FALL] ? (!trig_s && trig_d_reg)
                                              : (trig_s && !trig_d_reg);
  assign ev_pos = event_pos(evofs_reg, frmlen_reg);

  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pend_reg                  <= 1'b0;
      arm_reg                   <= `PTS_ARM_IDLE;
      running_reg               <= 1'b0;
      bit_cnt_reg               <= 16'h0000;
      point_reg                 <= 6'h00;
      serial_data_o             <= 1'b0;
      frame_event_o             <= 1'b0;
      baseband_trigger_port_a_o <= 1'b0;
    end else if (!run_en) begin
      pend_reg    <= 1'b0;
      arm_reg     <= `PTS_ARM_IDLE;
      running_reg <= 1'b0;
      frame_event_o <= 1'b0;
    end else begin
      if (bit_fall) begin
        baseband_trigger_port_a_o <= pend_reg;
        if (pend_reg) begin
          pend_reg    <= trig_edge;
          running_reg <= running_reg && !cont ? 1'b1 : 1'b0;
          if (!(running_reg && !cont)) begin
            arm_reg <= `PTS_ARM_START;
          end
        end else if (cont && !running_reg && arm_reg == `PTS_ARM_IDLE) begin
          arm_reg  <= `PTS_ARM_START;
          pend_reg <= trig_edge;
        end else if (trig_edge) begin
          pend_reg <= 1'b1;
        end
      end else if (trig_edge) begin
        pend_reg <= 1'b1;
      end
      if (bit_rise) begin
        if (arm_reg == `PTS_ARM_START) begin
          arm_reg <= `PTS_ARM_LAST;
        end else if (arm_reg == `PTS_ARM_LAST) begin
          arm_reg       <= `PTS_ARM_IDLE;
          running_reg   <= 1'b1;
          bit_cnt_reg   <= 16'h0000;
          point_reg     <= 6'h00;
          serial_data_o <= patword_reg[0];
          frame_event_o <= (ev_pos == 16'h0000);
        end else if (running_reg) begin
          if (bit_cnt_reg >= frmlen_reg - 16'h0001) begin
            bit_cnt_reg <= 16'h0000;
            running_reg <= cont;
          end else begin
            bit_cnt_reg <= bit_cnt_reg + 16'h0001;
          end
          point_reg <= (point_reg >= wlast_reg) ? 6'h00
                                                : point_reg + 6'h01;
          serial_data_o <= patword_reg[bit_cnt_reg[4:0] + 5'h01];
          frame_event_o <= running_reg &&
            (((bit_cnt_reg >= frmlen_reg - 16'h0001) ? 16'h0000
              : bit_cnt_reg + 16'h0001) == ev_pos);
        end else begin
          frame_event_o <= 1'b0;
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // external serial receive
  // --------------------------------------------------------------------
  reg [31:0] rx_shift_reg;
  reg [4:0]  rx_cnt_reg;
  reg        symstart_reg;
  wire [4:0] rx_cnt_next;

  // sync high restarts the count at the symbol's first bit
  assign rx_cnt_next = (pins_sync[3] || rx_cnt_reg >= symlen_reg)
                       ? 5'h01 : rx_cnt_reg + 5'h01;

  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_shift_reg <= 32'h0000_0000;
      rx_cnt_reg   <= 5'h00;
      rxsym_reg    <= 32'h0000_0000;
      symstart_reg <= 1'b0;
    end else begin
      symstart_reg <= 1'b0;
      // clock limit is met by 4 samples a period at 50 MHz
      if (ext_fall) begin
        rx_shift_reg <= {rx_shift_reg[30:0], pins_sync[2]};
        symstart_reg <= pins_sync[3];
        rx_cnt_reg   <= rx_cnt_next;
        // a symbol completes on its last bit, not at the next sync
        if (rx_cnt_next == symlen_reg) begin
          rxsym_reg <= {rx_shift_reg[30:0], pins_sync[2]};
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // markers, routing, polarity, data enable
  // --------------------------------------------------------------------
  wire [3:0] flags;
  wire [7:0] sources;
  reg  [3:0] routed;
  integer    m;

  ptsdp_marker_mem u_mem (
    .clock_i    (clock_i),
    .wr_en_i    (mem_we),
    .wr_addr_i  (waddr_reg),
    .wr_flags_i (wval[3:0]),
    .rd_addr_i  (point_reg),
    .rd_flags_o (flags)
  );

  assign sources = {1'b0, !data_enable_b_o, symstart_reg, frame_event_o,
                    flags & {4{running_reg}}};

  always @* begin
    routed = 4'h0;
    for (m = 0; m < 4; m = m + 1) begin
      routed[m] = sources[mkroute_reg[m*3 +: 3]];
    end
  end

  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      marker_o        <= 4'h0;
      data_enable_b_o <= 1'b1;
    end else begin
      marker_o        <= routed ^ mkpol_reg;
      data_enable_b_o <= !(ctrl_reg[`PTS_CTRL_EXTGATE] && running_reg);
    end
  end

endmodule // ptsdp_top

`default_nettype wire

// [testbench/ptsdp_top_properties.sv]
/* Port timing checker for ptsdp_top.
   Assumes reset BITDIV and the internal bit clock driven out. */
`timescale 1ns/100ps
`default_nettype none
module ptsdp_top_properties (
  input wire clock_i,
  input wire rst_b_i,
  input wire s_axi_awready_o,
  input wire s_axi_bvalid_o,
  input wire s_axi_bready_i,
  input wire s_axi_arready_o,
  input wire s_axi_rvalid_o,
  input wire s_axi_rready_i,
  input wire serial_data_o,
  input wire data_clock_o,
  input wire frame_event_o,
  input wire baseband_trigger_port_a_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  a_bvalid_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
    s_axi_bvalid_o) else $error("bvalid dropped early");
  a_rvalid_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
    s_axi_rvalid_o) else $error("rvalid dropped early");
  a_aw_blocked: assert property (s_axi_bvalid_o |-> !s_axi_awready_o)
    else $error("awready during response");
  a_ar_blocked: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("arready during read data");
  a_trig_at_fall: assert property (
    $rose(baseband_trigger_port_a_o) |-> !data_clock_o)
    else $error("trigger taken off the falling bit clock");
  a_first_bit: assert property (
    $rose(baseband_trigger_port_a_o) |-> ##[2:12] $rose(frame_event_o))
    else $error("first frame bit late");
  a_clk_rate: assert property (
    $rose(data_clock_o) |=> data_clock_o) else $error("bit clock too fast");
  a_data_edge: assert property (
    $changed(serial_data_o) |-> data_clock_o)
    else $error("serial data moved off the bit clock rise");
endmodule // ptsdp_top_properties
bind ptsdp_top ptsdp_top_properties chk_i (.*);
`default_nettype wire

// [testbench/ptsdp_far_end.sv]
/* External equipment model: pattern trigger and serial data source.
   Assumes a 48 ns data clock that stands low between frames. */
`timescale 1ns/100ps
`default_nettype none
module ptsdp_far_end (
  output var logic trig_o,
  output var logic eclk_o,
  output var logic edata_o,
  output var logic esync_o
);
  initial {trig_o, eclk_o, edata_o, esync_o} = 4'b0011;
  task automatic trig(input int width_ns);
    trig_o = 1'b1;
    #(width_ns) trig_o = 1'b0;
  endtask
  // released data and sync lines float to the pull-up level
  task automatic send(input logic [7:0] sym);
    for (int i = 7; i >= 0; i--) begin
      {eclk_o, edata_o, esync_o} = {1'b1, sym[i], i == 7};
      #24 eclk_o = 1'b0;
      #24;
    end
    {edata_o, esync_o} = 2'b11;
  endtask
endmodule // ptsdp_far_end
`default_nettype wire

// [testbench/ptsdp_top_bench.sv]
/* Self-checking bench for ptsdp_top.
   Assumes ptsdp_far_end drives the external pins. */
`timescale 1ns/100ps
`default_nettype none
`include "ptsdp_map.vh"
module ptsdp_top_bench;
  logic        clock_i, rst_b_i, s_axi_awvalid_i, s_axi_wvalid_i;
  logic        s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i;
  logic [7:0]  s_axi_awaddr_i, s_axi_araddr_i;
  logic [31:0] s_axi_wdata_i, got;
  logic [3:0]  s_axi_wstrb_i = 4'hF;
  logic [1:0]  resp;
  wire         s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
  wire         s_axi_arready_o, s_axi_rvalid_o, pattern_trigger_input_i;
  wire         ext_data_clock_i, ext_data_i, ext_symbol_sync_i;
  wire         serial_data_o, data_clock_o, frame_event_o, data_enable_b_o;
  wire         baseband_trigger_port_a_o;
  wire  [1:0]  s_axi_bresp_o, s_axi_rresp_o;
  wire  [31:0] s_axi_rdata_o;
  wire  [3:0]  marker_o;
  int          err_count = 0, n_compared = 0, cyc = 0;
  ptsdp_top uut (.*);
  ptsdp_far_end far (.trig_o(pattern_trigger_input_i),
    .eclk_o(ext_data_clock_i), .edata_o(ext_data_i),
    .esync_o(ext_symbol_sync_i));
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    {s_axi_awaddr_i, s_axi_wdata_i} <= {a, d};
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= 3'b111;
    do begin
      @(posedge clock_i);
      if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
      if (s_axi_bvalid_o) s_axi_bready_i <= 1'b0;
    end while (s_axi_bready_i);
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock_i);
    {s_axi_araddr_i, s_axi_arvalid_i, s_axi_rready_i} <= {a, 2'b11};
    do begin
      @(posedge clock_i);
      if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
      if (s_axi_rvalid_o)
        {s_axi_rready_i, got, resp} <= {1'b0, s_axi_rdata_o, s_axi_rresp_o};
    end while (s_axi_rready_i);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic t_regs;
    rd(`PTS_OFS_CTRL);
    chk(got, 32'h0000_0010);
    rd(8'hFC);
    chk({30'h0000_0000, resp}, {30'h0000_0000, `PTS_RESP_SLVERR});
  endtask
  task automatic t_rx;
    wr(`PTS_OFS_SYMLEN, 32'h0000_0008);
    far.send(8'hA5);
    repeat (20) @(posedge clock_i);
    rd(`PTS_OFS_RXSYM);
    chk(got, 32'h0000_00A5);
  endtask
  task automatic t_trig;
    wr(`PTS_OFS_PATWORD, 32'h0000_0001);
    wr(`PTS_OFS_WAVEDAT, 32'h0000_0001);
    wr(`PTS_OFS_MKPOL, 32'h0000_0002);
    wr(`PTS_OFS_CTRL, 32'h0000_0031);
    far.trig(10);
    for (int i = 0; i < 100 && frame_event_o !== 1'b1; i++) @(posedge clock_i);
    chk({31'h0, frame_event_o}, 32'h0000_0001);
    chk({31'h0, serial_data_o}, 32'h0000_0001);
    repeat (2) @(posedge clock_i);
    chk({28'h0, marker_o}, 32'h0000_0003);
    chk({31'h0, data_enable_b_o}, 32'h0000_0000);
  endtask
  task automatic end_sim;
    if (err_count == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clock_i) if (++cyc == 20000) begin
    err_count++;
    end_sim;
  end
  initial begin
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, rst_b_i} = 4'h0;
    {s_axi_arvalid_i, s_axi_rready_i} = 2'b00;
    {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} = 48'h0000_0000_0000;
    repeat (4) @(posedge clock_i);
    rst_b_i <= 1'b1;
    t_regs;
    t_rx;
    t_trig;
    end_sim;
  end
endmodule // ptsdp_top_bench
`default_nettype wire
